/* File: hdl/vmchk_pkg.sv */
package vmchk_pkg;
	// register word indices; byte address is index * 4
	localparam int unsigned REG_CTRL      = 0;
	localparam int unsigned REG_STATUS    = 1;
	localparam int unsigned REG_CAUSE     = 2;
	localparam int unsigned REG_EVT_INFO  = 3;
	localparam int unsigned REG_ERR_CODE  = 4;
	localparam int unsigned REG_INSTR_LEN = 5;
	localparam int unsigned REG_ENTRY_CTL = 6;
	localparam int unsigned REG_EXIT_CTL  = 7;
	localparam int unsigned REG_ENV       = 8;
	localparam int unsigned REG_MSR_CNT   = 9;
	localparam int unsigned REG_MSR_LO    = 10;
	localparam int unsigned REG_MSR_HI    = 11;
	localparam int unsigned REG_CR3_LO    = 12;
	localparam int unsigned REG_CR3_HI    = 13;
	localparam int unsigned REG_PAT_LO    = 14;
	localparam int unsigned REG_PAT_HI    = 15;
	localparam int unsigned REG_EFER      = 16;
	localparam int unsigned REG_CR4       = 17;
	localparam int unsigned REG_RIP_LO    = 18;
	localparam int unsigned REG_RIP_HI    = 19;
	localparam int unsigned REG_SEL_CS_SS = 20;
	localparam int unsigned REG_SEL_DS_ES = 21;
	localparam int unsigned REG_SEL_FS_GS = 22;
	localparam int unsigned REG_SEL_TR    = 23;
	localparam int unsigned NUM_REGS      = 24;
	localparam int unsigned FIRST_RW      = 3;
	localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;

	// control / status bits
	localparam int unsigned CTRL_START    = 0;
	localparam int unsigned ST_BUSY       = 0;
	localparam int unsigned ST_PASS       = 1;
	localparam int unsigned ST_FAIL       = 2;
	localparam int unsigned ST_RESTORED   = 3;

	// entry control bits
	localparam int unsigned EN_LONG_GUEST = 0;
	localparam int unsigned EN_ENTER_SMM  = 1;
	localparam int unsigned EN_DEACT_DUAL = 2;
	localparam int unsigned EN_UNRESTRICT = 3;
	localparam int unsigned EN_GUEST_PE   = 4;
	// exit control bits
	localparam int unsigned EX_HOST_AS64  = 0;
	localparam int unsigned EX_LOAD_PAT   = 1;
	localparam int unsigned EX_LOAD_EFER  = 2;
	// processor environment bits
	localparam int unsigned ENV_SMM       = 0;
	localparam int unsigned ENV_LMA       = 1;
	localparam int unsigned ENV_MTF_SUP   = 2;
	localparam int unsigned ENV_ADDR32    = 3;
	localparam int unsigned ENV_HAS64     = 4;
	localparam int unsigned ENV_PAW_LSB   = 8;

	// architectural field positions
	localparam int unsigned EFER_LME      = 8;
	localparam int unsigned EFER_LMA      = 10;
	localparam logic [31:0] EFER_RSVD     = 32'hffff_f2fe;
	localparam int unsigned PHYSICAL_EXTENSION_ENABLE       = 5;
	localparam int unsigned CONTEXT_ID_ENABLE     = 17;
	localparam logic [2:0]  IT_EXT_INT    = 3'h0;
	localparam logic [2:0]  IT_RSVD       = 3'h1;
	localparam logic [2:0]  IT_NMI        = 3'h2;
	localparam logic [2:0]  IT_HW_EXC     = 3'h3;
	localparam logic [2:0]  IT_SW_INT     = 3'h4;
	localparam logic [2:0]  IT_PRIV_SW    = 3'h5;
	localparam logic [2:0]  IT_SW_EXC     = 3'h6;
	localparam logic [2:0]  IT_OTHER      = 3'h7;
	localparam logic [7:0]  NMI_VECTOR    = 8'h02;
	localparam logic [7:0]  MAX_HW_VECTOR = 8'h1f;
	localparam logic [3:0]  MAX_INSTR_LEN = 4'hf;
	localparam int unsigned MSR_ENTRY_SZ  = 16;
	localparam int unsigned LIN_WIDTH     = 48;

	// one fail bit per check group, mirrored in the cause register
	typedef enum logic [4:0] {
		C_ITYPE, C_NMI_VEC, C_HW_VEC, C_OTHER_VEC, C_ERR_FLAG, C_INFO_RSVD,
		C_ERR_CODE, C_ILEN, C_MSR_ALIGN, C_MSR_END, C_MSR_32, C_SMM_OUT,
		C_SMM_BOTH, C_CR3, C_PAT, C_EFER, C_SEL_BITS, C_SEL_ZERO,
		C_AS_MODE, C_AS_ZERO, C_AS_ONE, C_NUM
	} vmchk_cause_t;

	typedef struct packed {
		logic        valid;
		logic [18:0] rsvd;
		logic        deliver_err;
		logic [2:0]  itype;
		logic [7:0]  vector;
	} vmchk_evt_info_t;

	typedef struct packed {
		logic        busy;
		logic        pass;
		logic        fail;
		logic        restored;
	} vmchk_status_t;
endpackage : vmchk_pkg

/* File: hdl/vmchk_entry_checker.sv */
`timescale 1ns/1ps
// Functional notes
// - valid event rejects type 1, 7 without trap
// - injected nmi needs vector 2
// - hardware exception vector at most 31
// - other event needs vector 0
// - error flag exactly for error-code exceptions, except unrestricted guest without pe
// - valid event needs reserved bits 30:12 zero
// - error flag requires error code 31:15 zero
// - software events need length 1 to 15
// - msr area aligned 16, within address width
// - msr area last byte within address width
// - 32-bit limit keeps both addresses low
// - outside smm both smm controls zero
// - smm controls never both set
// - host page base high bits zero
// - pat bytes only 0,1,4,5,6,7
// - efer reserved zero, long bits match size
// - host selectors have privilege, indicator zero
// - code, task selectors not zero; stack too for 32-bit host
// - address-size controls match long mode
// - 32-bit host: no pcid, low ip
// - 64-bit host: pae set, canonical ip
// - on pass, load guest, fall back host
module vmchk_entry_checker (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [6:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        guest_done_i,
	input  wire logic        guest_fail_i,
	output logic             guest_load_o,
	output logic             monitor_clear_o,
	output logic             host_restore_o,
	output logic             entry_pass_o,
	output logic             entry_fail_o
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_CHECK = 3'b010,
		S_GUEST = 3'b100
	} vmchk_state_t;

	logic [31:0]                regs_q [vmchk_pkg::NUM_REGS];
	logic [vmchk_pkg::C_NUM-1:0] cause_d;
	logic [vmchk_pkg::C_NUM-1:0] cause_q;
	vmchk_pkg::vmchk_status_t   status_q;
	vmchk_state_t               state_q;
	logic                       ack_q;
	logic [31:0]                rdata_q;
	logic                       req;
	logic [4:0]                 widx;
	logic                       start;
	logic                       checks_ok;
	logic                       enter_guest;
	logic                       late_fail;

	function automatic logic above_width(input logic [63:0] a,
		input logic [7:0] w);
		above_width = (w < 8'd64) && ((a >> w) != 64'h0);
	endfunction : above_width

	function automatic logic canonical(input logic [63:0] a);
		logic [63:0] hi;
		hi = a >> (vmchk_pkg::LIN_WIDTH - 1);
		canonical = (hi == 64'h0) || (&hi[64-vmchk_pkg::LIN_WIDTH:0]);
	endfunction : canonical

	function automatic logic sel_ok(input logic [15:0] s);
		sel_ok = (s[2:0] == 3'h0);
	endfunction : sel_ok

	function automatic logic [63:0] word64(input int unsigned lo);
		word64 = {regs_q[lo+1], regs_q[lo]};
	endfunction : word64

	// vectors whose exceptions push an error code
	function automatic logic has_err_code(input logic [7:0] v);
		case (v)
			8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11: begin
				has_err_code = 1'b1;
			end
			default: begin
				has_err_code = 1'b0;
			end
		endcase
	endfunction : has_err_code

	// memory types a host may load into the attribute msr
	function automatic logic pat_type_ok(input logic [7:0] t);
		case (t)
			8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07: begin
				pat_type_ok = 1'b1;
			end
			default: begin
				pat_type_ok = 1'b0;
			end
		endcase
	endfunction : pat_type_ok

	// decoded fields
	vmchk_pkg::vmchk_evt_info_t evt;
	logic [31:0] ectl;
	logic [31:0] xctl;
	logic [31:0] env;
	logic [7:0]  paw;
	logic [63:0] msr_a;
	logic [65:0] msr_end;
	logic [63:0] cr3;
	logic [63:0] pat;
	logic [31:0] efer;
	logic [31:0] cr4;
	logic [63:0] host_instruction_pointer;
	logic [15:0] sel [7];
	logic        as64;
	logic        has64;
	logic        sw_evt;
	logic        err_vec;
	logic        need_err;
	logic        pat_bad;
	logic [6:0]  sel_bad;
	logic [7:0]  pat_byte_bad;

	always_comb begin
		evt    = vmchk_pkg::vmchk_evt_info_t'(regs_q[vmchk_pkg::REG_EVT_INFO]);
		ectl   = regs_q[vmchk_pkg::REG_ENTRY_CTL];
		xctl   = regs_q[vmchk_pkg::REG_EXIT_CTL];
		env    = regs_q[vmchk_pkg::REG_ENV];
		paw    = env[vmchk_pkg::ENV_PAW_LSB +: 8];
		msr_a  = word64(vmchk_pkg::REG_MSR_LO);
		cr3    = word64(vmchk_pkg::REG_CR3_LO);
		pat    = word64(vmchk_pkg::REG_PAT_LO);
		host_instruction_pointer    = word64(vmchk_pkg::REG_RIP_LO);
		efer   = regs_q[vmchk_pkg::REG_EFER];
		cr4    = regs_q[vmchk_pkg::REG_CR4];
		as64   = xctl[vmchk_pkg::EX_HOST_AS64];
		has64  = env[vmchk_pkg::ENV_HAS64];
		// wide sum so a huge count cannot wrap the end address
		msr_end = {2'b00, msr_a}
			+ {30'h0, regs_q[vmchk_pkg::REG_MSR_CNT], 4'h0}
			- 66'h1;
		sel[0] = regs_q[vmchk_pkg::REG_SEL_CS_SS][15:0];
		sel[1] = regs_q[vmchk_pkg::REG_SEL_CS_SS][31:16];
		sel[2] = regs_q[vmchk_pkg::REG_SEL_DS_ES][15:0];
		sel[3] = regs_q[vmchk_pkg::REG_SEL_DS_ES][31:16];
		sel[4] = regs_q[vmchk_pkg::REG_SEL_FS_GS][15:0];
		sel[5] = regs_q[vmchk_pkg::REG_SEL_FS_GS][31:16];
		sel[6] = regs_q[vmchk_pkg::REG_SEL_TR][15:0];
		sw_evt = (evt.itype == vmchk_pkg::IT_SW_INT)
			|| (evt.itype == vmchk_pkg::IT_SW_EXC)
			|| (evt.itype == vmchk_pkg::IT_PRIV_SW);
		err_vec = has_err_code(evt.vector);
		need_err = (!ectl[vmchk_pkg::EN_UNRESTRICT]
			|| ectl[vmchk_pkg::EN_GUEST_PE])
			&& (evt.itype == vmchk_pkg::IT_HW_EXC) && err_vec;
	end

	// one flag per byte and per selector, folded into the cause below
	for (genvar g = 0; g < 8; g++) begin : g_pat
		assign pat_byte_bad[g] = !pat_type_ok(pat[g*8 +: 8]);
	end
	assign pat_bad = |pat_byte_bad;

	for (genvar g = 0; g < 7; g++) begin : g_sel
		assign sel_bad[g] = !sel_ok(sel[g]);
	end

	// every check is independent; the cause register shows all that failed
	always_comb begin
		cause_d = '0;
		if (evt.valid) begin
			cause_d[vmchk_pkg::C_ITYPE] = (evt.itype == vmchk_pkg::IT_RSVD)
				|| (evt.itype == vmchk_pkg::IT_OTHER
				&& !env[vmchk_pkg::ENV_MTF_SUP]);
			cause_d[vmchk_pkg::C_NMI_VEC] = (evt.itype == vmchk_pkg::IT_NMI)
				&& (evt.vector != vmchk_pkg::NMI_VECTOR);
			cause_d[vmchk_pkg::C_HW_VEC] = (evt.itype == vmchk_pkg::IT_HW_EXC)
				&& (evt.vector > vmchk_pkg::MAX_HW_VECTOR);
			cause_d[vmchk_pkg::C_OTHER_VEC] =
				(evt.itype == vmchk_pkg::IT_OTHER)
				&& (evt.vector != 8'h00);
			cause_d[vmchk_pkg::C_ERR_FLAG] =
				(evt.deliver_err != need_err);
			cause_d[vmchk_pkg::C_INFO_RSVD] = (evt.rsvd != 19'h0);
			cause_d[vmchk_pkg::C_ERR_CODE] = evt.deliver_err
				&& (regs_q[vmchk_pkg::REG_ERR_CODE][31:15] != 17'h0);
			cause_d[vmchk_pkg::C_ILEN] = sw_evt
				&& ((regs_q[vmchk_pkg::REG_INSTR_LEN] == 32'h0)
				|| (regs_q[vmchk_pkg::REG_INSTR_LEN]
				> {28'h0, vmchk_pkg::MAX_INSTR_LEN}));
		end
		if (regs_q[vmchk_pkg::REG_MSR_CNT] != 32'h0) begin
			cause_d[vmchk_pkg::C_MSR_ALIGN] = (msr_a[3:0] != 4'h0)
				|| above_width(msr_a, paw);
			cause_d[vmchk_pkg::C_MSR_END] = msr_end[65:64] != 2'b00
				|| above_width(msr_end[63:0], paw);
			cause_d[vmchk_pkg::C_MSR_32] = env[vmchk_pkg::ENV_ADDR32]
				&& ((msr_a[63:32] != 32'h0)
				|| (msr_end[65:32] != 34'h0));
		end
		cause_d[vmchk_pkg::C_SMM_OUT] = !env[vmchk_pkg::ENV_SMM]
			&& (ectl[vmchk_pkg::EN_ENTER_SMM]
			|| ectl[vmchk_pkg::EN_DEACT_DUAL]);
		cause_d[vmchk_pkg::C_SMM_BOTH] = ectl[vmchk_pkg::EN_ENTER_SMM]
			&& ectl[vmchk_pkg::EN_DEACT_DUAL];
		cause_d[vmchk_pkg::C_CR3] = has64 && ((cr3[63:52] != 12'h0)
			|| above_width(cr3, paw));
		cause_d[vmchk_pkg::C_PAT] = xctl[vmchk_pkg::EX_LOAD_PAT]
			&& pat_bad;
		cause_d[vmchk_pkg::C_EFER] = xctl[vmchk_pkg::EX_LOAD_EFER]
			&& (((efer & vmchk_pkg::EFER_RSVD) != 32'h0)
			|| (efer[vmchk_pkg::EFER_LMA] != as64)
			|| (efer[vmchk_pkg::EFER_LME] != as64));
		cause_d[vmchk_pkg::C_SEL_BITS] = |sel_bad;
		cause_d[vmchk_pkg::C_SEL_ZERO] = (sel[0] == 16'h0)
			|| (sel[6] == 16'h0)
			|| (!as64 && sel[1] == 16'h0);
		if (!has64) begin
			cause_d[vmchk_pkg::C_AS_MODE] = ectl[vmchk_pkg::EN_LONG_GUEST]
				|| as64;
		end else begin
			cause_d[vmchk_pkg::C_AS_MODE] = env[vmchk_pkg::ENV_LMA]
				? !as64
				: (ectl[vmchk_pkg::EN_LONG_GUEST] || as64);
			cause_d[vmchk_pkg::C_AS_ZERO] = !as64
				&& (ectl[vmchk_pkg::EN_LONG_GUEST]
				|| cr4[vmchk_pkg::CONTEXT_ID_ENABLE]
				|| host_instruction_pointer[63:32] != 32'h0);
			cause_d[vmchk_pkg::C_AS_ONE] = as64
				&& (!cr4[vmchk_pkg::PHYSICAL_EXTENSION_ENABLE] || !canonical(host_instruction_pointer));
		end
	end

	// wishbone slave: one-cycle answer, unmapped reads give zero
	assign req   = wb_cyc_i && wb_stb_i && !ack_q;
	assign widx  = wb_adr_i[6:2];
	assign start = req && wb_we_i && wb_sel_i[0]
		&& (widx == 5'(vmchk_pkg::REG_CTRL))
		&& wb_dat_i[vmchk_pkg::CTRL_START];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// fields are writable only while no entry is in flight
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < vmchk_pkg::NUM_REGS; i++) begin
				regs_q[i] <= vmchk_pkg::RESET_VALUE;
			end
		end else if (req && wb_we_i && !status_q.busy
			&& widx >= 5'(vmchk_pkg::FIRST_RW)
			&& widx < 5'(vmchk_pkg::NUM_REGS)) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					regs_q[widx][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0;
		end else if (req && !wb_we_i) begin
			if (widx == 5'(vmchk_pkg::REG_STATUS)) begin
				rdata_q <= {28'h0, status_q};
			end else if (widx == 5'(vmchk_pkg::REG_CAUSE)) begin
				rdata_q <= 32'(cause_q);
			end else if (widx >= 5'(vmchk_pkg::FIRST_RW)
				&& widx < 5'(vmchk_pkg::NUM_REGS)) begin
				rdata_q <= regs_q[widx];
			end else begin
				rdata_q <= 32'h0;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// verdict of the host and control checks, one cycle after start
	assign checks_ok   = (cause_d == '0);
	assign enter_guest = (state_q == S_CHECK) && checks_ok;
	assign late_fail   = (state_q == S_GUEST) && guest_fail_i;

	// entry sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (start) begin
						state_q <= S_CHECK;
					end
				end
				S_CHECK: begin
					// guest checking and loading run together
					state_q <= checks_ok ? S_GUEST : S_IDLE;
				end
				S_GUEST: begin
					if (guest_fail_i || guest_done_i) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	// cause is kept until the next check so software can read it later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_q <= '0;
		end else if (state_q == S_CHECK) begin
			cause_q <= cause_d;
		end
	end

	// strobes towards the core, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			guest_load_o    <= 1'b0;
			monitor_clear_o <= 1'b0;
			host_restore_o  <= 1'b0;
		end else begin
			guest_load_o    <= enter_guest;
			monitor_clear_o <= enter_guest;
			host_restore_o  <= late_fail;
		end
	end

	// start clears the previous verdict
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (start) begin
						status_q <= '{busy: 1'b1, default: 1'b0};
					end
				end
				S_CHECK: begin
					if (checks_ok) begin
						status_q.pass <= 1'b1;
					end else begin
						status_q.busy <= 1'b0;
						status_q.fail <= 1'b1;
					end
				end
				S_GUEST: begin
					// a late failure wins over done in the same cycle
					if (late_fail) begin
						status_q.busy     <= 1'b0;
						status_q.pass     <= 1'b0;
						status_q.fail     <= 1'b1;
						status_q.restored <= 1'b1;
					end else if (guest_done_i) begin
						status_q.busy <= 1'b0;
					end
				end
			endcase
		end
	end

	assign entry_pass_o = status_q.pass && !status_q.busy;
	assign entry_fail_o = status_q.fail;
endmodule : vmchk_entry_checker

/* File: test/vmchk_entry_checker_asserts.sv */
`timescale 1ns/1ps
module vmchk_asserts (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [6:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        guest_done_i,
	input  wire logic        guest_fail_i,
	input  wire logic        guest_load_o,
	input  wire logic        monitor_clear_o,
	input  wire logic        host_restore_o,
	input  wire logic        entry_pass_o,
	input  wire logic        entry_fail_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic go;
	// start strobe as taken on the bus
	assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
		&& wb_adr_i == 7'h00 && wb_sel_i[0] && wb_dat_i[0];
	one_result_a:
		assert property (!(entry_pass_o && entry_fail_o))
		else $error("pass and fail high together");
	start_result_a:
		assert property (go |-> ##[2:3] (entry_fail_o || guest_load_o))
		else $error("no verdict after start");
	start_clear_a:
		assert property (go |-> ##1 (!entry_pass_o)[*2])
		else $error("pass shown while checking");
	load_mon_a:
		assert property (guest_load_o |-> monitor_clear_o)
		else $error("guest load without monitor clear");
	mon_load_a:
		assert property (monitor_clear_o |-> guest_load_o)
		else $error("monitor clear without guest load");
	load_pulse_a:
		assert property (guest_load_o |=> !guest_load_o)
		else $error("guest load longer than a pulse");
	restore_cause_a:
		assert property (host_restore_o |-> $past(guest_fail_i))
		else $error("host restore without guest failure");
	restore_fail_a:
		assert property (host_restore_o |-> ##[0:1] entry_fail_o)
		else $error("host restore not reported as failure");
	bus_ack_a:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
	cover property (guest_load_o);
	cover property (host_restore_o);
	cover property ($rose(entry_fail_o));
endmodule : vmchk_asserts

bind vmchk_entry_checker vmchk_asserts vmchk_asserts_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .guest_done_i(guest_done_i),
	.guest_fail_i(guest_fail_i), .guest_load_o(guest_load_o),
	.monitor_clear_o(monitor_clear_o), .host_restore_o(host_restore_o),
	.entry_pass_o(entry_pass_o), .entry_fail_o(entry_fail_o));

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, guest_done_i, guest_fail_i;
	logic [6:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, e;
	logic        wb_ack_o, guest_load_o, monitor_clear_o, host_restore_o;
	logic        entry_pass_o, entry_fail_o;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'hb8ee;
	int          n_fail = 0, checked = 0, tick = 0, loads = 0;

	always #5 clk_i = ~clk_i;

	vmchk_entry_checker vmchk_entry_checker_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .guest_done_i(guest_done_i),
		.guest_fail_i(guest_fail_i), .guest_load_o(guest_load_o),
		.monitor_clear_o(monitor_clear_o), .host_restore_o(host_restore_o),
		.entry_pass_o(entry_pass_o), .entry_fail_o(entry_fail_o));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task close_out;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task bus(input logic w, input logic [4:0] ix, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {ix, 2'b00};
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) n_fail++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task rd(input logic [4:0] ix, input logic [31:0] x);
		exp_q.push_back(x);
		bus(1'b0, ix, 32'h0);
	endtask : rd

	// write one field, start an entry, settle the guest phase, read verdict
	task r(input logic [4:0] ix, input logic [31:0] v, input int k);
		int n;
		int l;
		logic f;
		f = 1'b0;
		n = 0;
		l = loads;
		bus(1'b1, ix, v);
		bus(1'b1, 5'd0, 32'h1);
		// the load strobe is over before the start write returns
		@(negedge clk_i);
		while (loads == l && entry_fail_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		if (loads != l) begin
			seed = lfsr(seed);
			f = seed[0];
			repeat (1 + seed[2:1]) @(posedge clk_i);
			guest_fail_i <= f;
			guest_done_i <= !f;
			@(posedge clk_i);
			guest_fail_i <= 1'b0;
			guest_done_i <= 1'b0;
		end
		while (entry_pass_o !== 1'b1 && entry_fail_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 20) n_fail++;
		@(posedge clk_i);
		rd(5'd1, k >= 0 ? 32'h2 : f ? 32'h3 : 32'h4);
		// a late guest failure leaves the latched cause at zero
		rd(5'd2, k >= 0 ? 32'h1 << k : 32'h0);
	endtask : r

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			checked++;
			if (wb_dat_o !== e) begin
				n_fail++;
				$display("BAD %0t exp %h got %h", $time, e, wb_dat_o);
			end
		end
	end

	always @(posedge clk_i) begin
		tick++;
		if (guest_load_o === 1'b1) loads++;
		if (tick == 8000) begin
			n_fail++;
			close_out;
		end
	end

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, guest_done_i, guest_fail_i} = 5'h00;
		wb_adr_i = 7'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(5'd1, 32'h0);
		rd(5'd3, 32'h0);
		rd(5'd30, 32'h0);
		bus(1'b1, 5'd1, 32'hf);
		rd(5'd1, 32'h0);
		bus(1'b1, 5'd20, 32'h0010_0008);
		bus(1'b1, 5'd23, 32'h18);
		bus(1'b1, 5'd8, 32'h2400);
		r(3, 32'h0, -1);
		r(3, 32'h8000_0100, 0);
		r(3, 32'h8000_0700, 0);
		r(3, 32'h8000_0203, 1);
		r(3, 32'h8000_0202, -1);
		r(3, 32'h8000_0320, 2);
		r(3, 32'h8000_031f, -1);
		r(8, 32'h2404, -1);
		r(3, 32'h8000_0701, 3);
		r(3, 32'h8000_0700, -1);
		r(3, 32'h8000_030d, 4);
		r(3, 32'h8000_0b09, 4);
		r(3, 32'h8000_0b0d, -1);
		r(6, 32'h8, 4);
		r(6, 32'h18, -1);
		r(4, 32'h8000, 6);
		r(4, 32'h7fff, -1);
		r(3, 32'h8000_1000, 5);
		r(3, 32'h8000_0400, 7);
		r(5, 32'hf, -1);
		r(3, 32'h0, -1);
		r(10, 32'h8, -1);
		r(9, 32'h1, 8);
		r(10, 32'hffff_fff0, -1);
		r(8, 32'h2408, -1);
		r(9, 32'h2, 10);
		r(9, 32'h0, -1);
		r(6, 32'h2, 11);
		r(8, 32'h2401, -1);
		r(6, 32'h6, 12);
		r(6, 32'h0, -1);
		r(21, 32'h4, 16);
		r(21, 32'h0, -1);
		r(23, 32'h0, 17);
		r(23, 32'h18, -1);
		r(17, 32'h20, -1);
		r(8, 32'h2412, 18);
		r(7, 32'h1, -1);
		r(17, 32'h0, 20);
		r(17, 32'h20, -1);
		r(19, 32'h8000, 20);
		r(19, 32'hffff_8000, -1);
		r(19, 32'h0, -1);
		r(13, 32'h10, 13);
		r(13, 32'h8, -1);
		r(13, 32'h0, -1);
		r(7, 32'h3, -1);
		r(15, 32'h0200_0000, 14);
		r(15, 32'h0706_0504, -1);
		r(7, 32'h5, 15);
		r(16, 32'h500, -1);
		r(16, 32'h502, 15);
		r(7, 32'h0, 18);
		r(8, 32'h2410, -1);
		r(20, 32'h8, 17);
		r(20, 32'h0010_0008, -1);
		r(17, 32'h2_0020, 19);
		r(17, 32'h0, -1);
		r(11, 32'hf, -1);
		r(9, 32'h2, 9);
		close_out;
	end
endmodule : testbench
